// *** rtl/txo_tx_options.v ***
// Purpose: transmit option logic: collision window start, fcs append, excessive deferral and abort
// Assumes: bit_tick is a one-cycle pulse from the encoder per line bit; stream bytes arrive in time
// Notes:   bits go out least significant first; prdata is latched in the apb setup cycle
`include "txo_regs.vh"

module txo_tx_options #(
	parameter DEFER_CYCLES = `TXO_DEFER_CYCLES
)(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// frame byte stream from the descriptor side
	input  wire [7:0]  in_data,
	input  wire        in_valid,
	input  wire        in_last,
	output wire        in_ready,
	// line side through the encoder
	input  wire        bit_tick,
	input  wire        carrier_sense,
	input  wire        collision,
	output wire        tx_data,
	output reg         tx_en,
	// interrupt
	output wire        irq
);

	// one-hot states
	localparam [5:0] S_IDLE  = 6'h01;
	localparam [5:0] S_DEFER = 6'h02;
	localparam [5:0] S_PRE   = 6'h04;
	localparam [5:0] S_DATA  = 6'h08;
	localparam [5:0] S_FCS   = 6'h10;
	localparam [5:0] S_ABORT = 6'h20;

	reg [5:0]  state;
	reg [3:0]  ctrl;
	reg [3:0]  frame_status;
	reg [3:0]  int_stat;
	reg [3:0]  int_mask;
	reg [31:0] shifter;
	reg [31:0] crc;
	reg [2:0]  bit_cnt;
	reg [4:0]  fcs_cnt;
	reg [2:0]  pre_cnt;
	reg        last_loaded;
	reg        owc_run;
	reg [9:0]  owc_cnt;
	reg        late_col;
	reg [3:0]  events;
	reg [3:0]  next_int_stat;
	reg [31:0] next_rdata;

	wire       cwss   = ctrl[`TXO_CTRL_CWSS_BIT];
	wire       fcss   = ctrl[`TXO_CTRL_FCSS_BIT];
	wire       dt_off = ctrl[`TXO_CTRL_DTOFF_BIT];
	wire       programmable_tx_interrupt   = ctrl[`TXO_CTRL_PROGRAMMABLE_TX_INTERRUPT_BIT];
	wire       deferring = state[1];
	wire       expired;
	wire       byte_end  = bit_tick && (bit_cnt == 3'h7);
	wire       load_data = byte_end && ((state[2] && pre_cnt == 3'h7) || (state[3] && !last_loaded));
	wire       wr_en     = psel && penable && pwrite;
	wire       mapped;

	// crc-32 over one bit, reflected form for lsb-first transmission
	function [31:0] crc_bit;
		input [31:0] c;
		input        b;
		begin
			crc_bit = (c[0] ^ b) ? ((c >> 1) ^ `TXO_CRC_POLY) : (c >> 1);
		end
	endfunction

	// address decode for the error answer; the read mux compares the offsets itself
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `TXO_CTRL_OFF) || (a == `TXO_STATUS_OFF) ||
				(a == `TXO_INT_STAT_OFF) || (a == `TXO_INT_MASK_OFF);
		end
	endfunction

	// timer is kept idle when switched off, so no flag and no abort can come of it
	txo_defer_timer #(
		.DEFER_CYCLES (DEFER_CYCLES)
	) u_defer (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (deferring && !dt_off),
		.expired (expired)
	);

	assign mapped   = is_mapped(paddr);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;
	assign tx_data  = tx_en & shifter[0];
	assign irq      = |(int_stat & int_mask);
	// stream byte is taken at the byte boundary, or dropped wholesale on abort
	assign in_ready = (load_data && in_valid) || state[5];

	// control and mask registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl     <= `TXO_CTRL_RESET;
			int_mask <= `TXO_INT_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == `TXO_CTRL_OFF)
				ctrl <= pwdata[3:0];
			else if (paddr == `TXO_INT_MASK_OFF)
				int_mask <= pwdata[3:0];
		end
	end

	// sticky interrupt bits: write one clears, a new event in the same cycle wins
	always @*
	begin
		next_int_stat = int_stat;
		if (wr_en && paddr == `TXO_INT_STAT_OFF)
			next_int_stat = int_stat & ~pwdata[3:0];
		next_int_stat = next_int_stat | events;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_stat <= `TXO_INT_RESET;
		else
			int_stat <= next_int_stat;
	end

	// read data latched in the setup cycle, presented in the access cycle
	always @*
	begin
		next_rdata = 32'h00000000;
		if (paddr == `TXO_CTRL_OFF)
			next_rdata[3:0] = ctrl;
		else if (paddr == `TXO_STATUS_OFF)
		begin
			next_rdata[3:0] = frame_status;
			next_rdata[`TXO_ST_DEFER_BIT] = deferring;
			next_rdata[`TXO_ST_BUSY_BIT]  = !state[0];
		end
		else if (paddr == `TXO_INT_STAT_OFF)
			next_rdata[3:0] = int_stat;
		else if (paddr == `TXO_INT_MASK_OFF)
			next_rdata[3:0] = int_mask;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= next_rdata;
	end

	// out-of-window collision timer counts line bits once started
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			owc_cnt  <= 10'h000;
			late_col <= 1'b0;
		end
		else if (state[0])
		begin
			owc_cnt  <= 10'h000;
			late_col <= 1'b0;
		end
		else
		begin
			if (owc_run && bit_tick && owc_cnt != `TXO_SLOT_BITS)
				owc_cnt <= owc_cnt + 10'h001;
			if (tx_en && collision && owc_run && owc_cnt == `TXO_SLOT_BITS)
				late_col <= 1'b1;
		end
	end

	// transmit sequencer: idle, defer, preamble, data, fcs, abort
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state        <= S_IDLE;
			shifter      <= 32'h00000000;
			crc          <= `TXO_CRC_INIT;
			bit_cnt      <= 3'h0;
			fcs_cnt      <= 5'h00;
			pre_cnt      <= 3'h0;
			last_loaded  <= 1'b0;
			owc_run      <= 1'b0;
			tx_en        <= 1'b0;
			frame_status <= `TXO_STATUS_RESET;
			events       <= 4'h0;
		end
		else
		begin
			events <= 4'h0;
			case (state)
			S_IDLE:
			begin
				owc_run <= 1'b0;
				if (in_valid)
				begin
					if (programmable_tx_interrupt)
						events[`TXO_INT_PROGRAMMABLE_TX_INTERRUPT_BIT] <= 1'b1;
					if (carrier_sense)
						state <= S_DEFER;
					else
					begin
						state   <= S_PRE;
						shifter <= {24'h000000, `TXO_PREAMBLE_BYTE};
						tx_en   <= 1'b1;
						bit_cnt <= 3'h0;
						pre_cnt <= 3'h0;
					end
				end
			end
			S_DEFER:
			begin
				if (expired)
				begin
					// flag only when the timer ran; frame is dropped
					state <= S_ABORT;
					events[`TXO_INT_OVERRUN_BIT] <= 1'b1;
				end
				else if (!carrier_sense)
				begin
					state   <= S_PRE;
					shifter <= {24'h000000, `TXO_PREAMBLE_BYTE};
					tx_en   <= 1'b1;
					bit_cnt <= 3'h0;
					pre_cnt <= 3'h0;
				end
			end
			S_ABORT:
			begin
				if (in_valid && in_last)
				begin
					state <= S_IDLE;
					frame_status <= 4'h0;
					frame_status[`TXO_ST_OVERRUN_BIT] <= 1'b1;
					frame_status[`TXO_ST_ABORT_BIT]   <= 1'b1;
					events[`TXO_INT_DONE_BIT] <= 1'b1;
				end
			end
			S_PRE:
			begin
				if (bit_tick)
				begin
					if (cwss && pre_cnt == 3'h0 && bit_cnt == 3'h0)
						owc_run <= 1'b1;
					bit_cnt <= bit_cnt + 3'h1;
					shifter <= shifter >> 1;
					if (byte_end)
					begin
						pre_cnt <= pre_cnt + 3'h1;
						if (pre_cnt == `TXO_PREAMBLE_LAST)
							shifter <= {24'h000000, `TXO_SFD_BYTE};
						else if (pre_cnt == 3'h7)
						begin
							// delimiter just went out
							if (!cwss)
								owc_run <= 1'b1;
							state       <= S_DATA;
							crc         <= `TXO_CRC_INIT;
							shifter     <= {24'h000000, in_data};
							last_loaded <= in_last || !in_valid;
						end
						else
							shifter <= {24'h000000, `TXO_PREAMBLE_BYTE};
					end
				end
			end
			S_DATA:
			begin
				if (bit_tick)
				begin
					crc     <= crc_bit(crc, shifter[0]);
					bit_cnt <= bit_cnt + 3'h1;
					shifter <= shifter >> 1;
					if (byte_end)
					begin
						// an empty stream ends the data field here rather than sending a stale byte
						if (!last_loaded && in_valid)
						begin
							shifter     <= {24'h000000, in_data};
							last_loaded <= in_last;
						end
						else if (fcss)
						begin
							// frame ends straight after the last data byte
							state        <= S_IDLE;
							tx_en        <= 1'b0;
							frame_status <= {late_col, 3'h0};
							events[`TXO_INT_DONE_BIT] <= 1'b1;
							events[`TXO_INT_LATECOL_BIT] <= late_col;
						end
						else
						begin
							state   <= S_FCS;
							shifter <= ~crc_bit(crc, shifter[0]);
							fcs_cnt <= 5'h00;
						end
					end
				end
			end
			S_FCS:
			begin
				if (bit_tick)
				begin
					shifter <= shifter >> 1;
					fcs_cnt <= fcs_cnt + 5'h01;
					if (fcs_cnt == 5'h1F)
					begin
						state        <= S_IDLE;
						tx_en        <= 1'b0;
						frame_status <= {late_col, 3'h4};
						events[`TXO_INT_DONE_BIT] <= 1'b1;
						events[`TXO_INT_LATECOL_BIT] <= late_col;
					end
				end
			end
			default:
				state <= S_IDLE;
			endcase
		end
	end

endmodule

// *** shared/txo_regs.vh ***
// Purpose: register map, field positions, reset values and timing counts of the transmit option block
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes:   included by every design file of the block
`ifndef TXO_REGS_VH
`define TXO_REGS_VH

// register byte offsets
`define TXO_CTRL_OFF        12'h000
`define TXO_STATUS_OFF      12'h004
`define TXO_INT_STAT_OFF    12'h008
`define TXO_INT_MASK_OFF    12'h00C

// control register fields
`define TXO_CTRL_CWSS_BIT   0
`define TXO_CTRL_FCSS_BIT   1
`define TXO_CTRL_DTOFF_BIT  2
`define TXO_CTRL_PROGRAMMABLE_TX_INTERRUPT_BIT   3
`define TXO_CTRL_RESET      4'h0

// frame status register fields
`define TXO_ST_OVERRUN_BIT  0
`define TXO_ST_ABORT_BIT    1
`define TXO_ST_FCS_BIT      2
`define TXO_ST_LATECOL_BIT  3
`define TXO_ST_DEFER_BIT    4
`define TXO_ST_BUSY_BIT     5
`define TXO_STATUS_RESET    4'h0

// interrupt status and mask fields
`define TXO_INT_DONE_BIT    0
`define TXO_INT_OVERRUN_BIT 1
`define TXO_INT_PROGRAMMABLE_TX_INTERRUPT_BIT    2
`define TXO_INT_LATECOL_BIT 3
`define TXO_INT_RESET       4'h0

// frame framing constants
`define TXO_PREAMBLE_BYTE   8'h55
`define TXO_SFD_BYTE        8'hD5
`define TXO_PREAMBLE_LAST   3'h6
`define TXO_CRC_INIT        32'hFFFFFFFF
`define TXO_CRC_POLY        32'hEDB88320
`define TXO_SLOT_BITS       10'h200

// timing: excessive deferral time and clock period
`define TXO_DEFER_TIME_NS   3200000
`define TXO_CLK_PERIOD_NS   40
`define TXO_DEFER_CYCLES    (`TXO_DEFER_TIME_NS / `TXO_CLK_PERIOD_NS)

`endif

// *** rtl/txo_defer_timer.v ***
// Purpose: excessive-deferral timer, counts clock cycles while the transmitter defers
// Assumes: run stays high for the whole deferral; dropping it restarts the count
// Notes:   expired is a level that holds until run falls
`include "txo_regs.vh"

module txo_defer_timer #(
	parameter DEFER_CYCLES = `TXO_DEFER_CYCLES
)(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// control
	input  wire        run,
	// result
	output reg         expired
);

	reg [23:0] count;

	// count only continuous deferral; any break clears the count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count   <= 24'h000000;
			expired <= 1'b0;
		end
		else if (!run)
		begin
			count   <= 24'h000000;
			expired <= 1'b0;
		end
		else if (count == DEFER_CYCLES[23:0] - 24'h000001)
			expired <= 1'b1;
		else
			count <= count + 24'h000001;
	end

endmodule

// *** sim/txo_checker.sv ***
// Purpose: port checker for the transmit option block
// Assumes: one clock domain, async active-low reset
// Notes:   abort timing accepts DEFER_CYCLES - 1 to DEFER_CYCLES + 2 waited cycles for sampling lag
module txo_checker #(
	parameter DEFER_CYCLES = 20
)(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// stream and line
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic        bit_tick,
	input wire logic        carrier_sense,
	input wire logic        tx_data,
	input wire logic        tx_en
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_cnt;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// cycles of continuous deferral with a frame pending
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			wait_cnt <= 0;
		else
			wait_cnt <= (carrier_sense && in_valid && !tx_en) ? wait_cnt + 1 : 0;

	a_slverr_unmapped: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
		else $error("no error on unmapped access");
	a_slverr_mapped: assert property (psel && penable && paddr <= 12'h00C && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped access");
	a_unmapped_zero: assert property (psel && !penable && paddr > 12'h00C |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_line_quiet: assert property (!tx_en |-> !tx_data)
		else $error("line bit outside frame");
	a_start_clear: assert property ($rose(tx_en) |-> !$past(carrier_sense) ##0 tx_data)
		else $error("frame started on busy medium");
	a_bit_hold: assert property (tx_en && $past(tx_en) && !$past(bit_tick) |-> $stable(tx_data))
		else $error("line bit moved without tick");
	a_take_tick: assert property (tx_en && in_ready |-> bit_tick)
		else $error("byte taken off tick");
	a_abort_time: assert property ($rose(in_ready) && !tx_en |->
		wait_cnt >= DEFER_CYCLES - 1 && wait_cnt <= DEFER_CYCLES + 2)
		else $error("abort at wrong time");
	a_abort_silent: assert property (in_ready && !tx_en |=> !tx_en)
		else $error("aborted frame sent");

	cover property ($rose(in_ready) && !tx_en);
	cover property ($fell(tx_en));
	cover property (psel && penable && pslverr);
endmodule

// *** sim/txo_line_model.sv ***
// Purpose: medium side model: bit ticks, carrier and collision
// Assumes: ticks never back to back, as the encoder promises
// Notes:   records every bit seen while tx_en is high
module txo_line_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// from the device
	input  wire logic       tx_en,
	input  wire logic       tx_data,
	// scenario controls
	input  wire logic       busy,
	input  wire logic       slow,
	input  wire logic [9:0] col_tick,
	// to the device
	output logic            bit_tick,
	output logic            carrier_sense,
	output logic            collision
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div;
	logic [9:0] n;
	logic       q[$];

	// tick every 3 or 5 clocks; collision held three ticks from col_tick
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			div <= 3'h0;
			n <= 10'h0;
			{bit_tick, carrier_sense, collision} <= 3'h0;
		end
		else
		begin
			div <= (div == (slow ? 3'h4 : 3'h2)) ? 3'h0 : div + 3'h1;
			bit_tick <= (div == 3'h0);
			carrier_sense <= busy;
			if (bit_tick && tx_en)
				q.push_back(tx_data);
			n <= !tx_en ? 10'h0 : n + 10'(bit_tick);
			collision <= tx_en && col_tick != 10'h0 && n >= col_tick && n < col_tick + 10'h3;
		end
endmodule

// *** sim/tb.sv ***
// Purpose: self-checking bench for the transmit option block
// Assumes: deferral count cut to 20 cycles
// Notes:   expected bits come from a bench crc model
`include "txo_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam DC = 20;
	logic        pclk, presetn, psel, penable, pwrite, in_valid, in_last, busy, slow, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd, crc;
	logic [7:0]  in_data;
	logic [9:0]  col_tick;
	wire         pready, pslverr, in_ready, bit_tick, carrier_sense, collision, tx_data, tx_en, irq;
	wire  [31:0] prdata;
	int          mismatches, checks;
	logic        eb[$];

	txo_tx_options #(.DEFER_CYCLES(DC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .in_data, .in_valid, .in_last, .in_ready, .bit_tick, .carrier_sense,
		.collision, .tx_data, .tx_en, .irq);
	txo_line_model m (.pclk, .presetn, .tx_en, .tx_data, .busy, .slow, .col_tick, .bit_tick,
		.carrier_sense, .collision);

	always #20 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	// expected line bits, lsb first, crc optional
	task automatic push(input logic [7:0] b, input bit upd);
		for (int i = 0; i < 8; i++)
		begin
			eb.push_back(b[i]);
			if (upd)
				crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? `TXO_CRC_POLY : 32'h0);
		end
	endtask

	task automatic send(input int n);
		for (int k = 0; k < n; k++)
		begin
			in_data <= 8'($urandom);
			{in_valid, in_last} <= {1'b1, k == n - 1};
			do @(posedge pclk); while (!in_ready);
			push(in_data, 1);
		end
		{in_valid, in_last} <= 2'h0;
	endtask

	task automatic frame(input logic [3:0] c, input int n, input logic [9:0] col, input logic [3:0] st,
		input logic [3:0] ist, input bit h);
		apb(1, `TXO_CTRL_OFF, 32'(c));
		apb(0, `TXO_CTRL_OFF, 0);
		chk(rd, 32'(c));
		col_tick <= col;
		eb.delete();
		m.q.delete();
		crc = `TXO_CRC_INIT;
		for (int i = 0; i < 8; i++)
			push(i < 7 ? 8'h55 : 8'hD5, 0);
		fork
			send(n);
			if (h)
			begin
				repeat (3 * DC) @(posedge pclk);
				chk(irq, 1'b0);
				busy <= 1'b0;
			end
		join
		if (!c[1])
			for (int i = 0; i < 32; i++)
				eb.push_back(~crc[i]);
		while (tx_en) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk(m.q.size(), eb.size());
		foreach (eb[i]) chk(m.q[i], eb[i]);
		apb(0, `TXO_STATUS_OFF, 0);
		chk(rd, 32'(st));
		apb(0, `TXO_INT_STAT_OFF, 0);
		chk(rd, 32'(ist));
		chk(irq, 1'b1);
		apb(1, `TXO_INT_STAT_OFF, 32'hF);
	endtask

	task automatic tally_and_finish;
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial
	begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		tally_and_finish;
	end

	initial
	begin
		{pclk, presetn, psel, penable, pwrite, in_valid, in_last, busy, slow} = '0;
		{paddr, pwdata, in_data, col_tick} = '0;
		void'($urandom(47));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then one unmapped word
		for (int i = 0; i < 5; i++)
		begin
			apb(0, 12'(i * 4), 32'hFFFFFFFF);
			chk(rd, 0);
			chk(se, i == 4);
		end
		apb(1, `TXO_INT_MASK_OFF, 32'hF);
		frame(4'h8, 8, 0, 4'h4, 4'h5, 0);
		frame(4'h2, 8, 0, 4'h0, 4'h1, 0);
		slow <= 1'b1;
		frame(4'h1, 70, 540, 4'hC, 4'h9, 0);
		frame(4'h0, 70, 540, 4'h4, 4'h1, 0);
		slow <= 1'b0;
		busy <= 1'b1;
		frame(4'h4, 3, 0, 4'h4, 4'h1, 1);
		// timer on, medium never frees: frame must be dropped
		busy <= 1'b1;
		apb(1, `TXO_CTRL_OFF, 0);
		m.q.delete();
		send(3);
		chk(m.q.size(), 0);
		apb(0, `TXO_STATUS_OFF, 0);
		chk(rd, 32'h3);
		apb(0, `TXO_INT_STAT_OFF, 0);
		chk(rd, 32'h3);
		apb(1, `TXO_INT_MASK_OFF, 0);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1, `TXO_INT_STAT_OFF, 32'hF);
		busy <= 1'b0;
		tally_and_finish;
	end
endmodule

bind txo_tx_options txo_checker #(.DEFER_CYCLES(DEFER_CYCLES)) chk_i (.pclk, .presetn, .psel, .penable,
	.paddr, .pslverr, .prdata, .in_valid, .in_ready, .bit_tick, .carrier_sense, .tx_data, .tx_en);
